/* src/rx_tone_loader.v */
// Receive tone-pair detector loader: programming word port, parameter
// store, active parameter latch and two frequency measurements.
// Assumes writes are synchronous one-cycle strobes from the host interface
// and that tone edge and level inputs are already synchronous.
`timescale 1ns/1ns
`include "tone_loader_defs.vh"

// Notes on behaviour
// - Words 2-11 are filter one coefficients, two sections of b2 b1 b0 a2 a1.
// - Words 12-14 are cycle count, minimum and maximum of measurement one.
// - Words 15-27 are filter two coefficients then measurement two values.
// - Coefficients are 15-bit two's complement, value times 8192.
// - Each measurement times the programmed number of whole input cycles.
// - Count in 9.6 kHz ticks; below the minimum rejects the frequency.
// - A tick count above the maximum also rejects the frequency.
// - Level detect turns on at -42.0 dBm, off below -44.5 dBm.
// - New values stay inactive until the mode is next entered.
// - Reset defaults detect the 2130 Hz plus 2750 Hz pair.
// - Write only while ready flag set; write clears it, store sets it (a header sets it one cycle later, with no store).
// - Programming port is a 16-bit write-only register.
module rx_tone_loader (
  input wire REF_CLK_I,
  input wire RST_I,
  input wire PROG_WR_I,
  input wire [15:0] PROG_DATA_I,
  input wire PTD_MODE_I,
  input wire TONE1_EDGE_I,
  input wire TONE2_EDGE_I,
  input wire TONE1_LVL_ON_I,
  input wire TONE1_LVL_OFF_I,
  input wire TONE2_LVL_ON_I,
  input wire TONE2_LVL_OFF_I,
  output wire PROG_READY_O,
  output reg PROG_ERR_O,
  output reg [14:0] ACT_COEF_O,
  output reg [4:0] ACT_COEF_SEL_O,
  output reg TONE1_O,
  output reg TONE2_O,
  output reg PAIR_O
);
  localparam ST_HDR = 2'h0;
  localparam ST_PARAM = 2'h1;
  localparam ST_STORE = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [4:0] index;
  reg [14:0] word;
  reg ready;
  reg mode_d;
  reg [4:0] copy_idx;
  reg copying;
  reg [4:0] rd_addr;
  reg rd_valid;
  reg copy_valid;
  reg [4:0] copy_dst;
  wire [14:0] rd_data;
  wire store_we;

  // Active measurement parameters, copied on mode entry
  reg [14:0] ncyc1, min1, max1, ncyc2, min2, max2;

  // ***************************************************
  // Host word handshake
  // ***************************************************
  // Ready drops on any write and returns after the store, or one cycle later for a header word
  assign PROG_READY_O = ready & ~PROG_WR_I;
  assign store_we = (state == ST_STORE);

  always @* begin
    next_state = state;
    case (state)
      ST_HDR: begin
        if (PROG_WR_I && PROG_DATA_I == `HDR_WORD) begin
          next_state = ST_PARAM;
        end
      end
      ST_PARAM: begin
        if (PROG_WR_I) begin
          next_state = ST_STORE;
        end
      end
      ST_STORE: begin
        next_state = (index == `LAST_SLOT) ? ST_HDR : ST_PARAM;
      end
      default: next_state = ST_HDR;
    endcase
  end

  // Counter, word capture and flag; port itself holds nothing readable
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state <= ST_HDR;
      index <= 5'h00;
      word <= 15'h0000;
      ready <= 1'b1;
      PROG_ERR_O <= 1'b0;
    end else begin
      state <= next_state;
      if (PROG_WR_I) begin
        ready <= 1'b0;
      end else if (state != ST_STORE) begin
        ready <= 1'b1;
      end
      if (state == ST_HDR) begin
        index <= 5'h00;
        if (PROG_WR_I && PROG_DATA_I != `HDR_WORD) begin
          PROG_ERR_O <= 1'b1;
        end
      end
      if (state == ST_PARAM && PROG_WR_I) begin
        word <= PROG_DATA_I[14:0];
        // Bit 15 set is a host fault; word still counts to keep framing
        if (PROG_DATA_I[`WORD_MSB]) begin
          PROG_ERR_O <= 1'b1;
        end
      end
      if (state == ST_STORE) begin
        index <= index + 5'h01;
      end
      if (PROG_WR_I && state == ST_HDR && PROG_DATA_I == `HDR_WORD) begin
        PROG_ERR_O <= 1'b0;
      end
    end
  end

  // Words land in order: filter one, meas one, filter two, meas two
  tone_param_store u_store (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .we_i(store_we),
    .waddr_i(index),
    .wdata_i(word),
    .raddr_i(rd_addr),
    .rdata_o(rd_data)
  );

  // ***************************************************
  // Activation on mode entry
  // ***************************************************
  // Copy all 26 words only after reset or on a rising edge of the mode, so edits in
  // mode wait; costs 28 cycles of stale parameters after entry.
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      mode_d <= 1'b0;
      copying <= 1'b1;
      copy_idx <= 5'h00;
      rd_addr <= 5'h00;
      rd_valid <= 1'b0;
      copy_valid <= 1'b0;
      copy_dst <= 5'h00;
      ACT_COEF_O <= 15'h0000;
      ACT_COEF_SEL_O <= 5'h00;
      ncyc1 <= `DEF_NCYC;
      min1 <= `DEF1_MIN;
      max1 <= `DEF1_MAX;
      ncyc2 <= `DEF_NCYC;
      min2 <= `DEF2_MIN;
      max2 <= `DEF2_MAX;
    end else begin
      mode_d <= PTD_MODE_I;
      if (PTD_MODE_I && !mode_d) begin
        copying <= 1'b1;
        copy_idx <= 5'h00;
      end else if (copying) begin
        // Stop on the last slot so the read address never leaves the store
        if (copy_idx == `LAST_SLOT) begin
          copying <= 1'b0;
        end else begin
          copy_idx <= copy_idx + 5'h01;
        end
      end
      // Valid follows the address through both register stages
      rd_addr <= copy_idx;
      rd_valid <= copying;
      copy_valid <= rd_valid;
      copy_dst <= rd_addr;
      if (copy_valid) begin
        case (copy_dst)
          `M1_BASE + `M_NCYC: ncyc1 <= rd_data;
          `M1_BASE + `M_MIN: min1 <= rd_data;
          `M1_BASE + `M_MAX: max1 <= rd_data;
          `M2_BASE + `M_NCYC: ncyc2 <= rd_data;
          `M2_BASE + `M_MIN: min2 <= rd_data;
          `M2_BASE + `M_MAX: max2 <= rd_data;
          default: begin
            // Coefficients go out to the filter datapath one per cycle
            ACT_COEF_O <= rd_data;
            ACT_COEF_SEL_O <= coef_slot(copy_dst);
          end
        endcase
      end
    end
  end

  // Filter slot 0-9 for filter one, 10-19 for filter two
  function [4:0] coef_slot;
    input [4:0] a;
    begin
      if (a >= `F2_BASE) begin
        coef_slot = a - `F2_BASE + `COEF2_SLOT;
      end else begin
        coef_slot = a;
      end
    end
  endfunction

  // ***************************************************
  // 9.6 kHz tick and frequency measurement
  // ***************************************************
  reg [13:0] div;
  wire tick = (div == 14'h0000);

  // Free-running divider; tick phase is not tied to any tone edge
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      div <= 14'h0000;
    end else if (div == `TICK_LAST) begin
      div <= 14'h0000;
    end else begin
      div <= div + 14'h0001;
    end
  end

  reg [14:0] cyc1, cyc2, cnt1, cnt2;
  reg ok1, ok2, lvl1, lvl2;

  // Period within limits: reject below min or above max
  function in_range;
    input [14:0] cnt;
    input [14:0] lo;
    input [14:0] hi;
    begin
      in_range = (cnt >= lo) && (cnt <= hi);
    end
  endfunction

  // Count ticks over ncycles whole edges of each tone, then judge
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cyc1 <= 15'h0000;
      cyc2 <= 15'h0000;
      cnt1 <= 15'h0000;
      cnt2 <= 15'h0000;
      ok1 <= 1'b0;
      ok2 <= 1'b0;
    end else begin
      if (TONE1_EDGE_I) begin
        if (cyc1 + 15'h0001 >= ncyc1) begin
          ok1 <= in_range(cnt1 + {14'h0000, tick}, min1, max1);
          cyc1 <= 15'h0000;
          cnt1 <= 15'h0000;
        end else begin
          cyc1 <= cyc1 + 15'h0001;
          cnt1 <= (cnt1 == 15'h7FFF) ? cnt1 : cnt1 + {14'h0000, tick};
        end
      end else if (tick && cnt1 != 15'h7FFF) begin
        cnt1 <= cnt1 + 15'h0001;
      end
      if (TONE2_EDGE_I) begin
        if (cyc2 + 15'h0001 >= ncyc2) begin
          ok2 <= in_range(cnt2 + {14'h0000, tick}, min2, max2);
          cyc2 <= 15'h0000;
          cnt2 <= 15'h0000;
        end else begin
          cyc2 <= cyc2 + 15'h0001;
          cnt2 <= (cnt2 == 15'h7FFF) ? cnt2 : cnt2 + {14'h0000, tick};
        end
      end else if (tick && cnt2 != 15'h7FFF) begin
        cnt2 <= cnt2 + 15'h0001;
      end
    end
  end

  // ***************************************************
  // Level hysteresis and tone report
  // ***************************************************
  // On at the upper threshold, off only below the lower one
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      lvl1 <= 1'b0;
      lvl2 <= 1'b0;
      TONE1_O <= 1'b0;
      TONE2_O <= 1'b0;
      PAIR_O <= 1'b0;
    end else begin
      if (TONE1_LVL_ON_I) begin
        lvl1 <= 1'b1;
      end else if (TONE1_LVL_OFF_I) begin
        lvl1 <= 1'b0;
      end
      if (TONE2_LVL_ON_I) begin
        lvl2 <= 1'b1;
      end else if (TONE2_LVL_OFF_I) begin
        lvl2 <= 1'b0;
      end
      TONE1_O <= PTD_MODE_I & lvl1 & ok1;
      TONE2_O <= PTD_MODE_I & lvl2 & ok2;
      PAIR_O <= PTD_MODE_I & lvl1 & ok1 & lvl2 & ok2;
    end
  end
endmodule

/* src/tone_loader_defs.vh */
// Constants for the receive tone-pair detector program loader.
// Included by the loader and its parameter store; definitions only.
`ifndef TONE_LOADER_DEFS_VH
`define TONE_LOADER_DEFS_VH

// Programming word framing
`define HDR_WORD 16'h8001
`define WORD_MSB 15
`define LAST_INDEX 5'h1A
// Store slot of the 26th parameter word; slots run from zero
`define LAST_SLOT 5'h19
`define INDEX_W 5
`define PARAM_COUNT 27
// Offsets of each section inside the 26 parameter words
`define F1_BASE 5'h00
`define M1_BASE 5'h0A
`define F2_BASE 5'h0D
`define M2_BASE 5'h17
`define M_NCYC 5'h00
`define M_MIN 5'h01
`define M_MAX 5'h02
// b0 of each biquad section inside a filter's ten words
`define B0_S1 5'h02
`define B0_S2 5'h07
// First coefficient slot of filter two on the active stream
`define COEF2_SLOT 5'h0A
// Store timing: one write cycle, then flag back
`define STORE_CYCLES 2'h1
// 9.6 kHz tick from 100 MHz: 10417 cycles (rounded)
`define TICK_HZ 9600
`define CLK_HZ 100000000
`define TICK_DIV ((`CLK_HZ + `TICK_HZ / 2) / `TICK_HZ)
// Last divider count, TICK_DIV minus one, at the divider's width
`define TICK_LAST 14'h28B0
// Default measurement values for 2130 Hz and 2750 Hz, 10 cycles each
`define DEF_NCYC 15'h000A
`define DEF1_MIN 15'h002B
`define DEF1_MAX 15'h002E
`define DEF2_MIN 15'h0021
`define DEF2_MAX 15'h0024
`define DEF_COEF 15'h0000
`define DEF_B0 15'h0200

`endif

/* src/tone_param_store.v */
// Parameter memory for the tone detector: 26 words of 15 bits.
// Assumes one writer; read data is registered, one cycle after address.
`timescale 1ns/1ns
`include "tone_loader_defs.vh"

module tone_param_store (
  input wire clk_i,
  input wire rst_i,
  input wire we_i,
  input wire [4:0] waddr_i,
  input wire [14:0] wdata_i,
  input wire [4:0] raddr_i,
  output reg [14:0] rdata_o
);
  reg [14:0] mem [0:25];
  integer k;

  // Default word for each slot after reset
  function [14:0] default_word;
    input [4:0] a;
    begin
      case (a)
        `M1_BASE + `M_NCYC: default_word = `DEF_NCYC;
        `M1_BASE + `M_MIN: default_word = `DEF1_MIN;
        `M1_BASE + `M_MAX: default_word = `DEF1_MAX;
        `M2_BASE + `M_NCYC: default_word = `DEF_NCYC;
        `M2_BASE + `M_MIN: default_word = `DEF2_MIN;
        `M2_BASE + `M_MAX: default_word = `DEF2_MAX;
        // Both sections pass signal, so neither filter output is stuck at zero
        `F1_BASE + `B0_S1: default_word = `DEF_B0;
        `F1_BASE + `B0_S2: default_word = `DEF_B0;
        `F2_BASE + `B0_S1: default_word = `DEF_B0;
        `F2_BASE + `B0_S2: default_word = `DEF_B0;
        default: default_word = `DEF_COEF;
      endcase
    end
  endfunction

  // ***************************************************
  // Storage
  // ***************************************************
  // Reset restores the dual-tone defaults
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (k = 0; k < 26; k = k + 1) begin
        mem[k] <= default_word(k[4:0]);
      end
      rdata_o <= 15'h0000;
    end else begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

/* verif/tone_host_model.sv */
// Host side of the programming word port: one word per call.
// Assumes the ready flag settles within 1 ns of the clock edge.
`timescale 1ns/1ns
module tone_host_model (
  input wire clk_i,
  input wire ready_i,
  output reg wr_o,
  output reg [15:0] data_o
);
  initial begin
    wr_o = 1'b0;
    data_o = 16'h0000;
  end
  // ****************
  // Write one word
  // ****************
  // Flag is looked at after the edge, so the strobe never races it
  task send(input [15:0] w);
    begin
      @(posedge clk_i);
      #1;
      while (!ready_i) begin
        @(posedge clk_i);
        #1;
      end
      @(posedge clk_i);
      wr_o <= 1'b1;
      data_o <= w;
      @(posedge clk_i);
      wr_o <= 1'b0;
      data_o <= ~w; // Idle bus never shows the last word
    end
  endtask
endmodule

/* verif/rx_tone_loader_monitor.sv */
// Checker on the tone loader ports.
// Assumes the host keeps the ready-flag handshake.
`timescale 1ns/1ns
`include "tone_loader_defs.vh"
module rx_tone_loader_monitor (
  input wire REF_CLK_I,
  input wire RST_I,
  input wire PROG_WR_I,
  input wire [15:0] PROG_DATA_I,
  input wire PTD_MODE_I,
  input wire TONE1_LVL_ON_I,
  input wire TONE1_LVL_OFF_I,
  input wire TONE2_LVL_ON_I,
  input wire TONE2_LVL_OFF_I,
  input wire PROG_READY_O,
  input wire PROG_ERR_O,
  input wire TONE1_O,
  input wire TONE2_O,
  input wire PAIR_O
);
  reg [4:0] idx;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // Word position: 0 waits for the header
  always @(posedge REF_CLK_I) begin
    if (RST_I)
      idx <= 5'h00;
    else if (PROG_WR_I)
      idx <= (idx == 5'h00) ? ((PROG_DATA_I == `HDR_WORD) ? 5'h01 : 5'h00)
           : ((idx == `LAST_INDEX) ? 5'h00 : idx + 5'h01);
  end
  // ****************
  // Assertions
  // ****************
  AST_WR_DROPS_READY: assert property (PROG_WR_I |-> !PROG_READY_O)
    else $error("ready high in a write cycle");
  AST_HDR_READY: assert property (PROG_WR_I && idx == 5'h00 |=> !PROG_READY_O ##1 PROG_READY_O)
    else $error("ready late after header");
  AST_PAR_READY: assert property (PROG_WR_I && idx != 5'h00 && !PROG_DATA_I[15]
    |=> !PROG_READY_O ##1 !PROG_READY_O ##1 PROG_READY_O)
    else $error("ready timing wrong after parameter");
  AST_BAD_HDR: assert property (PROG_WR_I && idx == 5'h00 && PROG_DATA_I != `HDR_WORD
    |=> PROG_ERR_O)
    else $error("bad header not flagged");
  AST_GOOD_HDR: assert property (PROG_WR_I && idx == 5'h00 && PROG_DATA_I == `HDR_WORD
    |=> !PROG_ERR_O)
    else $error("good header left error set");
  AST_BIT15: assert property (PROG_WR_I && idx != 5'h00 && PROG_DATA_I[15] |=> PROG_ERR_O)
    else $error("parameter with top bit not flagged");
  AST_ERR_HOLDS: assert property (!PROG_WR_I |=> $stable(PROG_ERR_O))
    else $error("error flag moved without a write");
  AST_TONE1: assert property (TONE1_O |-> $past(PTD_MODE_I) && $past(TONE1_LVL_ON_I || !TONE1_LVL_OFF_I, 2))
    else $error("tone one without mode or level");
  AST_TONE2: assert property (TONE2_O |-> $past(PTD_MODE_I) && $past(TONE2_LVL_ON_I || !TONE2_LVL_OFF_I, 2))
    else $error("tone two without mode or level");
  AST_PAIR: assert property (PAIR_O |-> $past(PTD_MODE_I) && TONE1_O && TONE2_O)
    else $error("pair without tone one");
  AST_RESET: assert property (disable iff (1'b0) RST_I |=> !PROG_ERR_O && !TONE1_O && !PAIR_O)
    else $error("outputs not cleared by reset");
  // Main scenarios reached
  COV_LOAD: cover property (PROG_WR_I && idx == `LAST_INDEX);
  COV_MODE: cover property ($rose(PTD_MODE_I));
  COV_ERR: cover property ($rose(PROG_ERR_O));
endmodule
bind rx_tone_loader rx_tone_loader_monitor rx_tone_loader_monitor_i (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .PROG_WR_I(PROG_WR_I), .PROG_DATA_I(PROG_DATA_I), .PTD_MODE_I(PTD_MODE_I), .TONE1_LVL_ON_I(TONE1_LVL_ON_I),
  .TONE1_LVL_OFF_I(TONE1_LVL_OFF_I), .TONE2_LVL_ON_I(TONE2_LVL_ON_I), .TONE2_LVL_OFF_I(TONE2_LVL_OFF_I),
  .PROG_READY_O(PROG_READY_O), .PROG_ERR_O(PROG_ERR_O), .TONE1_O(TONE1_O), .TONE2_O(TONE2_O), .PAIR_O(PAIR_O));

/* verif/rx_tone_loader_tb.sv */
// Testbench for the tone loader: host model plus directed sequences.
// Assumes the loader top and its store are compiled first.
`timescale 1ns/1ns
`include "tone_loader_defs.vh"
module rx_tone_loader_tb;
  reg clk, rst, mode, en, e1, e2, on1, off1, on2, off2;
  wire wr, ready, err, t1, t2, pair;
  wire [15:0] data;
  wire [14:0] coef;
  wire [4:0] sel;
  reg [15:0] expv [0:19];
  reg [15:0] got [0:19];
  reg [14:0] hold;
  integer n_errors, check_count, k;
  rx_tone_loader rx_tone_loader_i (.REF_CLK_I(clk), .RST_I(rst), .PROG_WR_I(wr), .PROG_DATA_I(data),
    .PTD_MODE_I(mode), .TONE1_EDGE_I(e1), .TONE2_EDGE_I(e2), .TONE1_LVL_ON_I(on1), .TONE1_LVL_OFF_I(off1),
    .TONE2_LVL_ON_I(on2), .TONE2_LVL_OFF_I(off2), .PROG_READY_O(ready), .PROG_ERR_O(err),
    .ACT_COEF_O(coef), .ACT_COEF_SEL_O(sel), .TONE1_O(t1), .TONE2_O(t2), .PAIR_O(pair));
  tone_host_model tone_host_model_i (.clk_i(clk), .ready_i(ready), .wr_o(wr), .data_o(data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Edges far too fast for any period window but the wide-open one
  always @(posedge clk) begin
    e1 <= en & ~e1;
    e2 <= en & ~e2;
  end
  // ****************
  // Tasks
  // ****************
  task check(input [8*10-1:0] what, input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task test_done;
    begin
      $display("Checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Header then 26 words base+n; lim sets ncycles 1, min 0, max 1 in both
  // measurements. Ready stands low one cycle after a header, two after a word.
  task load(input [15:0] base, input lim);
    integer w;
    reg [15:0] v;
    begin
      tone_host_model_i.send(`HDR_WORD);
      #1 check("rdy_hdr", ready, 0);
      @(posedge clk);
      #1 check("rdy_hdr1", ready, 1);
      for (w = 2; w <= `PARAM_COUNT; w = w + 1) begin
        v = base + w[15:0];
        if (lim && (w == 12 || w == 14 || w == 25 || w == 27))
          v = 16'h0001;
        if (lim && (w == 13 || w == 26))
          v = 16'h0000;
        tone_host_model_i.send(v);
        #1 check("rdy_par", ready, 0);
        @(posedge clk);
        #1 check("rdy_par1", ready, 0);
      end
      // Word n lands in slot n-2; filter two starts at word 15
      for (w = 0; w < 20; w = w + 1)
        expv[w] = (w < 10) ? base + w[15:0] + 16'h0002 : base + w[15:0] + 16'h0005;
    end
  endtask
  // Last sighting of each slot wins, so stale values before the copy drop out
  task capture;
    integer c;
    begin
      for (c = 0; c < 20; c = c + 1)
        got[c] = 16'bx;
      for (c = 0; c < 60; c = c + 1) begin
        @(posedge clk);
        #1;
        if (sel < 5'h14)
          got[sel] = {1'b0, coef};
      end
      for (c = 0; c < 20; c = c + 1)
        check("coef", got[c], expv[c]);
    end
  endtask
  initial begin
    #200000;
    n_errors = n_errors + 1;
    test_done;
  end
  // ****************
  // Sequence
  // ****************
  initial begin
    n_errors = 0;
    check_count = 0;
    rst = 1'b1;
    {mode, en, on1, off1, on2, off2} = 6'h05;
    for (k = 0; k < 20; k = k + 1)
      expv[k] = (k % 5 == 2) ? {1'b0, `DEF_B0} : {1'b0, `DEF_COEF};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1 check("rst_rdy", {ready, err, t1, t2, pair}, 16'h0010);
    capture;
    tone_host_model_i.send(16'h1234);
    #1 check("err_hdr", err, 1);
    load(16'h0100, 1'b0);
    check("err_clr", err, 0);
    @(posedge clk) mode <= 1'b1;
    capture;
    @(posedge clk) {en, on1, on2, off1, off2} <= 5'h1C;
    repeat (40) begin
      @(posedge clk);
      #1 check("tones", {t1, t2, pair}, 0);
    end
    hold = coef;
    load(16'h0300, 1'b0);
    check("err_wrap", err, 0);
    check("coef_hold", coef, hold);
    @(posedge clk) mode <= 1'b0;
    repeat (3) @(posedge clk);
    mode <= 1'b1;
    capture;
    // Wide-open window: both tones and the pair must come up
    load(16'h0500, 1'b1);
    @(posedge clk) mode <= 1'b0;
    repeat (3) @(posedge clk);
    mode <= 1'b1;
    capture;
    check("tones_on", {t1, t2, pair}, 7);
    @(posedge clk) on1 <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check("hyst_hold", t1, 1);
    @(posedge clk) off1 <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("hyst_off", {t1, pair}, 0);
    tone_host_model_i.send(`HDR_WORD);
    tone_host_model_i.send(16'h8000);
    #1 check("err_b15", err, 1);
    test_done;
  end
endmodule
